// ### inc/dcr_pkg.sv
// constants and state layout of the dual wiper adjust and user store block
package dcr_pkg;

	// serial frame layout
	localparam int          WORD_BITS  = 24;        // bits in one command frame
	localparam logic [4:0]  FRAME_FULL = 5'h18;     // bit count of a complete frame
	localparam logic [4:0]  CNT_ZERO   = 5'h00;     // bit count of a bare strobe
	localparam int          CMD_HI     = 23;        // command nibble, top bit
	localparam int          CMD_LO     = 20;        // command nibble, low bit
	localparam int          ADDR_HI    = 19;        // address nibble, top bit
	localparam int          ADDR_LO    = 16;        // address nibble, low bit (wiper select)
	localparam int          DATA_HI    = 15;        // data field, top bit
	localparam int          DATA_LO    = 0;         // data field, low bit

	// wiper code
	localparam int          CODE_BITS  = 10;        // width of a wiper code
	localparam int          CODE_MSB   = 9;         // midscale bit of a wiper code
	localparam int          TAPS       = 1024;      // tap switches per channel
	localparam logic [9:0]  CODE_ZERO  = 10'h000;   // zero scale
	localparam logic [9:0]  CODE_ONE   = 10'h001;   // one step / log start point
	localparam logic [9:0]  CODE_MAX   = 10'h3ff;   // full scale

	// command codes
	localparam logic [3:0]  CMD_NOP     = 4'h0;
	localparam logic [3:0]  CMD_RESTORE = 4'h1;     // store image to one wiper
	localparam logic [3:0]  CMD_SAVE    = 4'h2;     // one wiper to its store image
	localparam logic [3:0]  CMD_WR_NV   = 4'h3;     // frame data to store word
	localparam logic [3:0]  CMD_LOG_DN1 = 4'h4;
	localparam logic [3:0]  CMD_LOG_DNA = 4'h5;
	localparam logic [3:0]  CMD_LIN_DN1 = 4'h6;
	localparam logic [3:0]  CMD_LIN_DNA = 4'h7;
	localparam logic [3:0]  CMD_RST_ALL = 4'h8;     // restore all wipers
	localparam logic [3:0]  CMD_RD_NV   = 4'h9;     // read store word next frame
	localparam logic [3:0]  CMD_RD_WIP  = 4'ha;     // read wiper next frame
	localparam logic [3:0]  CMD_WR_WIP  = 4'hb;     // frame data to wiper
	localparam logic [3:0]  CMD_LOG_UP1 = 4'hc;
	localparam logic [3:0]  CMD_LOG_UPA = 4'hd;
	localparam logic [3:0]  CMD_LIN_UP1 = 4'he;
	localparam logic [3:0]  CMD_LIN_UPA = 4'hf;

	// store map
	localparam logic [3:0]  ADDR_WIPER1 = 4'h0;     // wiper1_saved_setting
	localparam logic [3:0]  ADDR_WIPER2 = 4'h1;     // wiper2_saved_setting
	localparam logic [3:0]  ADDR_USER_FIRST = 4'h2; // user_word_first
	localparam logic [3:0]  ADDR_USER_LAST  = 4'he; // user_word_last
	localparam logic [3:0]  ADDR_TOL    = 4'hf;     // resistance_tolerance, read only
	localparam logic [15:0] WORD_ZERO   = 16'h0000;
	// factory contents: sign 1 = positive, 7 bit integer, 8 bit fraction (value arbitrary)
	localparam logic [15:0] TOL_WORD    = 16'h8100;
	localparam logic [15:0] WIPER1_IMG  = 16'h0200; // delivered wiper images
	localparam logic [15:0] WIPER2_IMG  = 16'h0200;
	localparam logic [15:0][15:0] STORE_INIT =
		{TOL_WORD, {13{WORD_ZERO}}, WIPER2_IMG, WIPER1_IMG};
	localparam logic [1023:0] TAP_ZERO = 1024'h1;  // tap of code zero

	// link phase, one-hot
	typedef enum logic [1:0] {
		LNK_IDLE  = 2'b01,
		LNK_FRAME = 2'b10
	} dcr_link_type;

	// whole block state
	typedef struct packed {
		logic               sclk_s1, sclk_s2, sclk_d;
		logic               cs_s1, cs_s2, cs_d;
		logic               sdi_s1, sdi_s2;
		logic               pr_s1, pr_s2, pr_d;
		dcr_link_type       link;
		logic [4:0]         cnt;
		logic [23:0]        shift;
		logic [23:0]        sdo_sh;
		logic [23:0]        last_cmd;
		logic               last_valid;
		logic               boot;
		logic [1:0][9:0]    wiper;
		logic [15:0][15:0]  store;
		logic [1:0][1023:0] tap;
	} dcr_state_type;

endpackage : dcr_pkg

// ### logic/dcr_wiper_ctl.sv
// dual wiper adjust, command re-execution and user store of the resistor
`timescale 1ns/1ps
// Operation
// R01 - single increment adds one step to wiper
// R02 - ganged increment raises both wipers
// R03 - decrement lowers one or both wipers
// R04 - log increment codes give plus 6 dB
// R05 - log decrement codes give minus 6 dB
// R06 - log up shifts left, down right
// R07 - log up from zero loads one
// R08 - log up at midscale forces full scale
// R09 - full scale stays under log up
// R10 - eleven log ups reach full scale
// R11 - log down drops lsb, truncating
// R12 - bare chip select strobe repeats command
// R13 - restore images at boot, command, preset
// R14 - user words written and read back
// R15 - thirteen user words at two to fourteen
// R16 - addresses zero, one hold wiper images
// R17 - tolerance word is read only
// R18 - tolerance word is sign magnitude
// R19 - exactly one tap switch is on
// R20 - linear and shift saturate at ends
// R21 - commands act at chip select release
// R22 - adjust commands ignore data bytes
// R23 - midscale means top bit set
// R24 - ganged update same cycle, own saturation
module dcr_wiper_ctl
	import dcr_pkg::*;
(
	input  wire logic             CORE_CLK,        // block clock, 125 MHz
	input  wire logic             SYS_RST,         // synchronous reset, high
	input  wire logic             CE,              // clock enable, freezes all state when low
	input  wire logic             SCLK,            // serial clock pin
	input  wire logic             CS_N,            // chip select pin, low in frame
	input  wire logic             SDI,             // serial data in
	input  wire logic             PRESET_STROBE_N, // preset strobe pin, low active
	output logic                  SDO,             // serial data out
	output logic [CODE_BITS-1:0]  WIPER1_CODE,     // wiper 1 setting register
	output logic [CODE_BITS-1:0]  WIPER2_CODE,     // wiper 2 setting register
	output logic [TAPS-1:0]       TAP1,            // wiper 1 tap switches
	output logic [TAPS-1:0]       TAP2             // wiper 2 tap switches
);

	// reset image: store keeps its delivered contents, boot asks for a restore
	localparam dcr_state_type ST_RST = '{
		cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1,
		pr_s1: 1'b1, pr_s2: 1'b1, pr_d: 1'b1,
		link: LNK_IDLE, boot: 1'b1, store: STORE_INIT,
		tap: {TAP_ZERO, TAP_ZERO}, default: '0};

	dcr_state_type        st_r;        // registered state
	dcr_state_type        st_nxt;      // next state
	logic                 sclk_rise;   // rising serial clock seen
	logic                 sclk_fall;   // falling serial clock seen
	logic                 cs_fall;     // frame opens
	logic                 cs_rise;     // frame closes
	logic                 pr_fall;     // preset strobe asserted
	logic                 exec;        // a command executes this cycle
	logic                 restore_any; // wipers reload from store this cycle
	logic [WORD_BITS-1:0] word;        // command being executed
	logic [3:0]           cmd;         // its command code
	logic [3:0]           addr;        // its address nibble
	logic                 sel;         // its wiper select bit

	// one adjust step of a wiper code for a given command
	function automatic logic [CODE_BITS-1:0] adjust(input logic [CODE_BITS-1:0] c,
		input logic [3:0] op);
		logic [CODE_BITS-1:0] r;
		r = c;
		case (op)
			CMD_LOG_DN1, CMD_LOG_DNA: begin
				r = c >> 1;                                   // lsb lost [R05] [R06] [R11]
			end
			CMD_LIN_DN1, CMD_LIN_DNA: begin
				r = (c == CODE_ZERO) ? CODE_ZERO : c - CODE_ONE; // floor [R03] [R20]
			end
			CMD_LOG_UP1, CMD_LOG_UPA: begin
				if (c == CODE_ZERO) begin
					r = CODE_ONE;                             // [R07]
				end else if (c[CODE_MSB]) begin
					r = CODE_MAX;                             // midscale or above [R08] [R09] [R23]
				end else begin
					r = c << 1;                               // doubling [R04] [R06] [R10]
				end
			end
			CMD_LIN_UP1, CMD_LIN_UPA: begin
				r = (c == CODE_MAX) ? CODE_MAX : c + CODE_ONE; // ceiling [R01] [R02] [R20]
			end
			default: begin
				r = c;
			end
		endcase
		return r;
	endfunction : adjust

	// true when an adjust command acts on both wipers
	function automatic logic is_gang(input logic [3:0] op);
		return (op == CMD_LOG_DNA) || (op == CMD_LIN_DNA) ||
			(op == CMD_LOG_UPA) || (op == CMD_LIN_UPA);
	endfunction : is_gang

	// true when a command is an adjust step of any kind
	function automatic logic is_step(input logic [3:0] op);
		return (op >= CMD_LOG_DN1 && op <= CMD_LIN_DNA) || (op >= CMD_LOG_UP1);
	endfunction : is_step

	// next state: pin sampling, frame shift, execution, restore, tap decode
	always_comb begin
		st_nxt      = st_r;
		sclk_rise   = 1'b0;
		sclk_fall   = 1'b0;
		cs_fall     = 1'b0;
		cs_rise     = 1'b0;
		pr_fall     = 1'b0;
		exec        = 1'b0;
		restore_any = 1'b0;
		word        = st_r.last_cmd;
		if (CE) begin
			// two stages on every pin; edges look at the second stage only
			st_nxt.sclk_s1 = SCLK;
			st_nxt.sclk_s2 = st_r.sclk_s1;
			st_nxt.sclk_d  = st_r.sclk_s2;
			st_nxt.cs_s1   = CS_N;
			st_nxt.cs_s2   = st_r.cs_s1;
			st_nxt.cs_d    = st_r.cs_s2;
			st_nxt.sdi_s1  = SDI;
			st_nxt.sdi_s2  = st_r.sdi_s1;
			st_nxt.pr_s1   = PRESET_STROBE_N;
			st_nxt.pr_s2   = st_r.pr_s1;
			st_nxt.pr_d    = st_r.pr_s2;
			sclk_rise = st_r.sclk_s2 & ~st_r.sclk_d;
			sclk_fall = ~st_r.sclk_s2 & st_r.sclk_d;
			cs_fall   = ~st_r.cs_s2 & st_r.cs_d;
			cs_rise   = st_r.cs_s2 & ~st_r.cs_d;
			pr_fall   = ~st_r.pr_s2 & st_r.pr_d;

			// frame phase
			case (st_r.link)
				LNK_IDLE: begin
					if (cs_fall) begin
						st_nxt.link = LNK_FRAME;
						st_nxt.cnt  = CNT_ZERO;
					end
				end
				LNK_FRAME: begin
					if (cs_rise) begin
						st_nxt.link = LNK_IDLE;
						// nothing acts before release [R21]
						if (st_r.cnt == FRAME_FULL) begin
							exec = 1'b1;
							word = st_r.shift;
						end else if (st_r.cnt == CNT_ZERO && st_r.last_valid) begin
							exec = 1'b1;                      // bare strobe repeats [R12]
							word = st_r.last_cmd;
						end
					end else begin
						// bits past the 24th are dropped; a long frame runs its first 24
						if (sclk_rise && st_r.cnt != FRAME_FULL) begin
							st_nxt.shift = {st_r.shift[WORD_BITS-2:0], st_r.sdi_s2};
							st_nxt.cnt   = st_r.cnt + 5'h01;
						end
						if (sclk_fall) begin
							st_nxt.sdo_sh = {st_r.sdo_sh[WORD_BITS-2:0], 1'b0};
						end
					end
				end
				default: begin
					st_nxt.link = LNK_IDLE;
				end
			endcase
		end
		cmd  = word[CMD_HI:CMD_LO];
		addr = word[ADDR_HI:ADDR_LO];
		sel  = word[ADDR_LO];

		// command execution, all in the release cycle
		if (exec) begin
			st_nxt.last_cmd   = word;
			st_nxt.last_valid = 1'b1;
			st_nxt.sdo_sh     = word;                         // echo for daisy chain
			if (is_step(cmd)) begin
				// data bytes never reach the adjust path [R22]
				for (int i = 0; i < 2; i++) begin
					if (is_gang(cmd) || sel == i[0]) begin
						st_nxt.wiper[i] = adjust(st_r.wiper[i], cmd); // [R24]
					end
				end
			end else begin
				case (cmd)
					CMD_RESTORE: begin
						st_nxt.wiper[sel] = st_r.store[{3'h0, sel}][CODE_BITS-1:0]; // [R13]
						restore_any = 1'b1;
					end
					CMD_SAVE: begin
						st_nxt.store[{3'h0, sel}] = {6'h00, st_r.wiper[sel]}; // [R16]
					end
					CMD_WR_NV: begin
						if (addr != ADDR_TOL) begin               // tolerance protected [R17]
							st_nxt.store[addr] = word[DATA_HI:DATA_LO]; // [R14] [R15]
						end
					end
					CMD_RST_ALL: begin
						restore_any = 1'b1;
					end
					CMD_RD_NV: begin
						// tolerance sits at the top word in its sign magnitude form [R18]
						st_nxt.sdo_sh = {word[CMD_HI:ADDR_LO], st_r.store[addr]}; // [R14]
					end
					CMD_RD_WIP: begin
						st_nxt.sdo_sh = {word[CMD_HI:ADDR_LO], 6'h00, st_r.wiper[sel]};
					end
					CMD_WR_WIP: begin
						st_nxt.wiper[sel] = word[CODE_BITS-1:0];
					end
					default: begin
						st_nxt.last_valid = st_r.last_valid;    // nop keeps last_valid; last_cmd and the echo still take its word
					end
				endcase
			end
		end

		// boot load, preset strobe and restore-all reload both wipers
		if ((CE && (st_r.boot || pr_fall)) || (exec && cmd == CMD_RST_ALL)) begin
			restore_any     = 1'b1;
			st_nxt.boot     = 1'b0;
			st_nxt.wiper[0] = st_r.store[ADDR_WIPER1][CODE_BITS-1:0]; // [R13] [R16]
			st_nxt.wiper[1] = st_r.store[ADDR_WIPER2][CODE_BITS-1:0]; // [R13] [R16]
		end

		// taps follow the new code in the same edge, so only one is ever on
		for (int i = 0; i < 2; i++) begin
			st_nxt.tap[i] = TAP_ZERO << st_nxt.wiper[i];      // [R19]
		end
	end

	// state register; freezing on CE is handled in the next-state logic
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from state bits
	assign SDO         = st_r.sdo_sh[WORD_BITS-1];
	assign WIPER1_CODE = st_r.wiper[0];
	assign WIPER2_CODE = st_r.wiper[1];
	assign TAP1        = st_r.tap[0];
	assign TAP2        = st_r.tap[1];

	// checks next to the logic they guard
	property p_lin_up_one;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		exec && cmd == CMD_LIN_UP1 && !sel && st_r.wiper[0] != CODE_MAX
		|=> st_r.wiper[0] == $past(st_r.wiper[0]) + CODE_ONE;
	endproperty
	a_lin_up_one: assert property (p_lin_up_one) else $error("single increment wrong"); // [R01]

	property p_lin_up_all;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		exec && cmd == CMD_LIN_UPA && st_r.wiper[0] != CODE_MAX
		|=> st_r.wiper[0] == $past(st_r.wiper[0]) + CODE_ONE && st_r.wiper[1] ==
			($past(st_r.wiper[1]) == CODE_MAX ? CODE_MAX : $past(st_r.wiper[1]) + CODE_ONE);
	endproperty
	a_lin_up_all: assert property (p_lin_up_all) else $error("ganged increment wrong"); // [R02]

	property p_lin_dn;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		exec && cmd == CMD_LIN_DN1 && sel && st_r.wiper[1] != CODE_ZERO
		|=> st_r.wiper[1] == $past(st_r.wiper[1]) - CODE_ONE && $stable(st_r.wiper[0]);
	endproperty
	a_lin_dn: assert property (p_lin_dn) else $error("decrement wrong"); // [R03]

	property p_log_zero;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		exec && cmd == CMD_LOG_UP1 && !sel && st_r.wiper[0] == CODE_ZERO
		|=> st_r.wiper[0] == CODE_ONE;
	endproperty
	a_log_zero: assert property (p_log_zero) else $error("log up from zero wrong"); // [R07]

	property p_log_sat;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		exec && cmd == CMD_LOG_UPA && st_r.wiper[1][CODE_MSB] |=> st_r.wiper[1] == CODE_MAX;
	endproperty
	a_log_sat: assert property (p_log_sat) else $error("log up saturation wrong"); // [R08]

	property p_log_dn;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		exec && cmd == CMD_LOG_DNA |=> st_r.wiper[1] == ($past(st_r.wiper[1]) >> 1);
	endproperty
	a_log_dn: assert property (p_log_dn) else $error("log down wrong"); // [R11]

	property p_dn_floor;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		exec && cmd == CMD_LIN_DNA && st_r.wiper[1] == CODE_ZERO |=> st_r.wiper[1] == CODE_ZERO;
	endproperty
	a_dn_floor: assert property (p_dn_floor) else $error("decrement below zero"); // [R20]

	property p_quiet;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		!exec && !restore_any |=> $stable(WIPER1_CODE) && $stable(WIPER2_CODE);
	endproperty
	a_quiet: assert property (p_quiet) else $error("wiper moved without release"); // [R21]

	property p_repeat;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		CE && st_r.link == LNK_FRAME && cs_rise && st_r.cnt == CNT_ZERO && st_r.last_valid
		|-> exec && word == st_r.last_cmd;
	endproperty
	a_repeat: assert property (p_repeat) else $error("bare strobe did not repeat"); // [R12]

	property p_tol;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		exec && cmd == CMD_WR_NV && addr == ADDR_TOL |=> $stable(st_r.store[ADDR_TOL]);
	endproperty
	a_tol: assert property (p_tol) else $error("tolerance word altered"); // [R17]

	property p_onehot;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		$onehot(TAP1) && TAP1[WIPER1_CODE] && $onehot(TAP2) && TAP2[WIPER2_CODE];
	endproperty
	a_onehot: assert property (p_onehot) else $error("tap decode not one-hot"); // [R19]

	property p_preset;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		CE && pr_fall && !exec |=> st_r.wiper[0] == $past(st_r.store[ADDR_WIPER1][CODE_BITS-1:0]);
	endproperty
	a_preset: assert property (p_preset) else $error("preset did not restore"); // [R13]

	c_inc: cover property (@(posedge CORE_CLK) exec && cmd == CMD_LIN_UP1);
	c_repeat: cover property (@(posedge CORE_CLK) exec && st_r.cnt == CNT_ZERO);
	c_read: cover property (@(posedge CORE_CLK) exec && cmd == CMD_RD_NV);
	c_preset: cover property (@(posedge CORE_CLK) CE && pr_fall);

endmodule : dcr_wiper_ctl

// ### test/dcr_host_model.sv
// host side serial master model that sends frames to the resistor block
`timescale 1ns/1ps
module dcr_host_model (
	input  wire logic clk,   // block clock, paces the link
	output logic      sclk,  // serial clock, stands low between frames
	output logic      cs_n,  // chip select, low in frame
	output logic      sdi,   // serial data to the device
	input  wire logic sdo    // serial data from the device
);
	localparam int HALF = 10; // half of the 160 ns link period in block clocks

	// idle link at time zero
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi  = 1'b0;
	end

	// one frame of n bits, msb first; n of zero gives a bare strobe
	task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rx);
		rx = 24'h0;
		@(negedge clk) cs_n = 1'b0;
		repeat (HALF) @(negedge clk);
		for (int i = 0; i < n; i++) begin // no clocks at all when n is zero
			sdi = w[23-i];
			repeat (HALF) @(negedge clk);
			sclk = 1'b1;
			rx = {rx[22:0], sdo};
			repeat (HALF) @(negedge clk);
			sclk = 1'b0;
		end
		repeat (HALF) @(negedge clk);
		cs_n = 1'b1; // the device acts on this release
		sdi  = ~sdi; // a released line must not keep its last value
		repeat (HALF) @(negedge clk);
	endtask : xfer
endmodule : dcr_host_model

// ### test/wiper_adjust_and_user_store_tb.sv
// self-checking bench of the wiper adjust and user store block
`timescale 1ns/1ps
module wiper_adjust_and_user_store_tb;
	import dcr_pkg::*;
	logic          core_clk, sys_rst, ce, sclk, cs_n, sdi, preset_strobe_n, sdo;
	logic [9:0]    wiper1_code, wiper2_code; // wiper setting registers
	logic [1023:0] tap1, tap2;               // tap switches
	logic [23:0]   rx;                       // last word seen on the link
	logic [15:0]   w;                        // word read from the store
	int            mismatches, n_tests;

	dcr_wiper_ctl i_dcr_wiper_ctl (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .CE(ce),
		.SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .PRESET_STROBE_N(preset_strobe_n), .SDO(sdo),
		.WIPER1_CODE(wiper1_code), .WIPER2_CODE(wiper2_code), .TAP1(tap1), .TAP2(tap2));
	dcr_host_model i_dcr_host_model (.clk(core_clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
		.sdo(sdo));

	// 125 MHz block clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// verdict, reached from the main sequence or the watchdog
	task automatic finish_test;
		$display("mismatches %0d comparisons %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test

	// compare of a code or word
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// compare of a tap switch vector
	task automatic chk_tap(input string what, input logic [1023:0] exp, input logic [1023:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_tap

	// both wipers with their taps, one switch on at the code's position
	task automatic chk_wip(input logic [9:0] e1, input logic [9:0] e2);
		chk("wiper1", 24'(e1), 24'(wiper1_code));
		chk("wiper2", 24'(e2), 24'(wiper2_code));
		chk_tap("tap1", TAP_ZERO << e1, tap1);
		chk_tap("tap2", TAP_ZERO << e2, tap2);
	endtask : chk_wip

	// full frame helpers
	task automatic cmd(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
		i_dcr_host_model.xfer({c, a, d}, 24, rx);
	endtask : cmd
	task automatic wr_wip(input logic sel, input logic [9:0] code);
		cmd(CMD_WR_WIP, {3'h0, sel}, {6'h0, code});
	endtask : wr_wip
	task automatic rd_nv(input logic [3:0] a, output logic [15:0] d);
		cmd(CMD_RD_NV, a, 16'h0);
		cmd(CMD_NOP, 4'h0, 16'h0); // answer shifts out in this frame
		d = rx[15:0];
	endtask : rd_nv

	// delivered state after reset
	task automatic t_boot;
		chk_wip(WIPER1_IMG[9:0], WIPER2_IMG[9:0]);
		rd_nv(ADDR_WIPER1, w);
		chk("store word 0", 24'(WIPER1_IMG), 24'(w));
		rd_nv(ADDR_WIPER2, w);
		chk("store word 1", 24'(WIPER2_IMG), 24'(w));
		rd_nv(ADDR_TOL, w);
		chk("tolerance", 24'(TOL_WORD), 24'(w));
	endtask : t_boot

	// linear steps with saturation, data bytes full of noise
	task automatic t_linear;
		wr_wip(1'b0, 10'h3fe);
		wr_wip(1'b1, 10'h001);
		cmd(CMD_LIN_UP1, 4'h0, 16'hffff);
		chk_wip(10'h3ff, 10'h001);
		cmd(CMD_LIN_UP1, 4'h0, 16'h5555);
		chk_wip(10'h3ff, 10'h001);
		cmd(CMD_LIN_DNA, 4'h0, 16'hffff);
		chk_wip(10'h3fe, 10'h000);
		cmd(CMD_LIN_DNA, 4'h0, 16'h0);
		chk_wip(10'h3fd, 10'h000);
		cmd(CMD_LIN_UPA, 4'h0, 16'h0);
		chk_wip(10'h3fe, 10'h001);
		cmd(CMD_LIN_DN1, 4'h1, 16'h0);
		chk_wip(10'h3fe, 10'h000);
	endtask : t_linear

	// six decibel steps, repeat strobe, short frame refused
	task automatic t_log;
		logic [9:0] e;
		e = 10'h000;
		wr_wip(1'b0, 10'h000);
		for (int i = 0; i < 11; i++) begin
			cmd(CMD_LOG_UP1, 4'h0, 16'h0);
			e = (e == CODE_ZERO) ? CODE_ONE : (e[CODE_MSB] ? CODE_MAX : e << 1);
			chk("log up step", 24'(e), 24'(wiper1_code));
		end
		chk("after eleven", 24'(CODE_MAX), 24'(wiper1_code));
		cmd(CMD_LOG_UP1, 4'h0, 16'h0);
		chk_wip(10'h3ff, 10'h000);
		wr_wip(1'b1, 10'h201);
		cmd(CMD_LOG_DN1, 4'h0, 16'h0);
		chk_wip(10'h1ff, 10'h201);
		i_dcr_host_model.xfer(24'h0, 0, rx);
		chk_wip(10'h0ff, 10'h201);
		cmd(CMD_LOG_UPA, 4'h0, 16'h0);
		chk_wip(10'h1fe, 10'h3ff);
		cmd(CMD_LOG_DNA, 4'h0, 16'h0);
		chk_wip(10'h0ff, 10'h1ff);
		wr_wip(1'b0, 10'h001);
		cmd(CMD_LOG_DN1, 4'h0, 16'h0);
		cmd(CMD_LOG_DN1, 4'h0, 16'h0);
		chk_wip(10'h000, 10'h1ff);
		i_dcr_host_model.xfer({CMD_LIN_UPA, 20'h0}, 12, rx);
		chk_wip(10'h000, 10'h1ff);
	endtask : t_log

	// user words, read-only tolerance, save and the command, restore-all and preset restore paths
	task automatic t_store;
		cmd(CMD_WR_NV, ADDR_USER_FIRST, 16'ha5c3);
		cmd(CMD_WR_NV, ADDR_USER_LAST, 16'h5a3c);
		rd_nv(ADDR_USER_FIRST, w);
		chk("user first", 24'h00a5c3, 24'(w));
		rd_nv(ADDR_USER_LAST, w);
		chk("user last", 24'h005a3c, 24'(w));
		cmd(CMD_WR_NV, ADDR_TOL, 16'h1234);
		rd_nv(ADDR_TOL, w);
		chk("tolerance kept", 24'(TOL_WORD), 24'(w));
		wr_wip(1'b0, 10'h155);
		cmd(CMD_SAVE, ADDR_WIPER1, 16'h0);
		rd_nv(ADDR_WIPER1, w);
		chk("saved wiper1", 24'h000155, 24'(w));
		wr_wip(1'b0, 10'h000);
		cmd(CMD_RESTORE, ADDR_WIPER1, 16'h0);
		chk("restored wiper1", 24'h000155, 24'(wiper1_code));
		cmd(CMD_WR_NV, ADDR_WIPER2, 16'h02aa);
		wr_wip(1'b0, 10'h000);
		wr_wip(1'b1, 10'h000);
		cmd(CMD_RST_ALL, 4'h0, 16'h0);
		chk_wip(10'h155, 10'h2aa);
		wr_wip(1'b0, 10'h000);
		wr_wip(1'b1, 10'h000);
		@(negedge core_clk) preset_strobe_n = 1'b0;
		repeat (10) @(negedge core_clk);
		preset_strobe_n = 1'b1;
		repeat (10) @(negedge core_clk);
		chk_wip(10'h155, 10'h2aa);
	endtask : t_store

	// wiper readback, then a preset strobe while the clock enable is low must be lost
	task automatic t_freeze;
		cmd(CMD_RD_WIP, 4'h1, 16'h0);
		cmd(CMD_NOP, 4'h0, 16'h0); // answer shifts out in this frame
		chk("wiper2 readback", {CMD_RD_WIP, 4'h1, 16'h02aa}, rx);
		wr_wip(1'b0, 10'h000);
		@(negedge core_clk) ce = 1'b0;
		preset_strobe_n = 1'b0;
		repeat (10) @(negedge core_clk);
		preset_strobe_n = 1'b1;
		repeat (10) @(negedge core_clk);
		chk_wip(10'h000, 10'h2aa);
		ce = 1'b1;
		repeat (10) @(negedge core_clk);
		chk_wip(10'h000, 10'h2aa);
	endtask : t_freeze

	// main sequence
	initial begin
		sys_rst         = 1'b1;
		ce              = 1'b1;
		preset_strobe_n = 1'b1;
		mismatches      = 0;
		n_tests         = 0;
		repeat (12) @(negedge core_clk);
		sys_rst = 1'b0;
		repeat (8) @(negedge core_clk);
		t_boot;
		t_linear;
		t_log;
		t_store;
		t_freeze;
		finish_test;
	end

	// watchdog, about two and a half times the expected run
	initial begin
		#600000;
		mismatches++;
		finish_test;
	end
endmodule : wiper_adjust_and_user_store_tb
